/* File: fcl_pkg.sv */
// Purpose: shared constants and types of the configuration loader
// Assumes: 10 MHz system clock
// Notes: flash opcodes follow the common serial flash command set
package fcl_pkg;
  localparam int CLK_NS = 100;
  localparam int WAKE_WAIT_NS = 30000;
  // least wait rounds up to whole cycles
  localparam int WAKE_WAIT_CYC = (WAKE_WAIT_NS + CLK_NS - 1) / CLK_NS;
  localparam logic [8:0] WAIT_LAST = 9'(WAKE_WAIT_CYC - 1);

  localparam logic [7:0] CMD_WAKE = 8'hAB;
  localparam logic [7:0] CMD_FAST_READ = 8'h0B;
  localparam logic [23:0] READ_ADDR = 24'h000000;
  localparam logic [8:0] WAKE_BITS_LAST = 9'h007;
  localparam logic [8:0] READ_BITS_LAST = 9'h01F;
  localparam logic [8:0] DUMMY_BITS_LAST = 9'h007;
  localparam logic [2:0] SPI_PH_LAST = 3'h7;

  localparam int SYNC_W = 46;
  localparam int MEM_AW = 6;
  localparam int MEM_DEPTH = 64;
  localparam logic [6:0] CFG_WORDS = 7'h40;
  localparam logic [5:0] WORD_BITS = 6'h20;

  // log2 of the data width
  localparam logic [2:0] LW_ACTIVE_MAX = 3'h2;
  localparam logic [2:0] LW_PASSIVE_MAX = 3'h5;
  localparam logic [2:0] LW_JTAG = 3'h0;

  localparam logic [SYNC_W-1:0] SYNC_RST = 46'h0;
  localparam logic [31:0] WORD_RST = 32'h0;

  typedef enum logic [1:0] {
    MODE_ACTIVE = 2'h0,
    MODE_PASSIVE = 2'h1,
    MODE_JTAG = 2'h2
  } fcl_mode_t;

  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_WAKE = 3'h1,
    ST_WAIT = 3'h2,
    ST_READ_CMD = 3'h3,
    ST_DUMMY = 3'h4,
    ST_DATA = 3'h5,
    ST_SLAVE = 3'h6,
    ST_DONE = 3'h7
  } fcl_state_t;
endpackage

/* File: fcl_mem_if.sv */
// Purpose: write and read path between loader and configuration memory
// Assumes: both ends on the system clock
// Notes: read data is registered inside the memory
interface fcl_mem_if;
  logic wr_en;
  logic [5:0] wr_addr;
  logic [31:0] wr_data;
  logic [5:0] rd_addr;
  logic [31:0] rd_data;

  modport loader (
    output wr_en,
    output wr_addr,
    output wr_data,
    output rd_addr,
    input rd_data
  );

  modport mem (
    input wr_en,
    input wr_addr,
    input wr_data,
    input rd_addr,
    output rd_data
  );
endinterface

/* File: fcl_cfg_mem.sv */
// Purpose: configuration memory, one write and one registered read port
// Assumes: synchronous active-high reset clears only the read register
// Notes: contents are volatile and undefined until loaded
module fcl_cfg_mem
  import fcl_pkg::*;
(
  // clock and reset
  input wire logic clock,
  input wire logic sys_rst,
  // memory port
  fcl_mem_if.mem mem_if
);
  logic [31:0] store [MEM_DEPTH];
  logic [31:0] rd_data_q;

  always_ff @(posedge clock)
  begin
    if (mem_if.wr_en)
    begin
      store[mem_if.wr_addr] <= mem_if.wr_data;
    end
  end

  always_ff @(posedge clock)
  begin
    if (sys_rst)
    begin
      rd_data_q <= WORD_RST;
    end
    else
    begin
      rd_data_q <= store[mem_if.rd_addr];
    end
  end

  assign mem_if.rd_data = rd_data_q;
endmodule

/* File: fcl_loader.sv */
// Purpose: configuration loader: active serial flash, passive and jtag loading
// Assumes: 10 MHz clock; every pin input passes two flip-flops
// Notes: serial clock is divided down, eight system cycles per flash bit

// Function
// R1: host holds config_reset_n low after power up, then raises it to start.
// R2: active mode: device drives the flash clock from its own clock.
// R3: first flash command in active mode is release from power down.
// R4: at least 30 us pass after the wake command before the next command.
// R5: then fast read from address zero, data read sequentially as bitstream.
// R6: passive mode: external master supplies select, clock and data.
// R7: widths: active 1/2/4, passive 1 to 32, jtag 1 bit.
// R8: jtag port loads the configuration as a third mode.
// R9: memory loads after every power up; no user mode before completion.
// R10: while config_reset_n is low stay idle; restart on every rising edge.
// R11: keep taking data until the whole bitstream is written, then release.
module fcl_loader
  import fcl_pkg::*;
(
  // clock and reset
  input wire logic clock,
  input wire logic sys_rst,
  // configuration control pins
  input wire logic config_reset_n,
  input wire logic [1:0] mode_sel,
  input wire logic [2:0] width_sel,
  // serial flash, active mode
  output logic flash_sclk,
  output logic flash_cs_n,
  output logic [3:0] flash_io_o,
  output logic [3:0] flash_io_oe_n,
  input wire logic [3:0] flash_io_i,
  // passive master
  input wire logic pas_clk,
  input wire logic pas_cs_n,
  input wire logic [31:0] pas_data,
  // jtag
  input wire logic jtag_tck,
  input wire logic jtag_tdi,
  // user side
  output logic user_mode,
  input wire logic [5:0] user_rd_addr,
  output logic [31:0] user_rd_data
);
  function automatic logic [5:0] fcl_bits(input logic [2:0] lw);
    fcl_bits = 6'h01 << lw;
  endfunction

  function automatic logic [31:0] fcl_mask(input logic [2:0] lw);
    fcl_mask = (lw == LW_PASSIVE_MAX) ? 32'hFFFFFFFF : ((32'h1 << fcl_bits(lw)) - 32'h1);
  endfunction

  function automatic logic spi_busy(input fcl_state_t st);
    spi_busy = (st == ST_WAKE) || (st == ST_READ_CMD) || (st == ST_DUMMY) || (st == ST_DATA);
  endfunction

  fcl_mem_if mem_if ();

  fcl_cfg_mem u_mem (
    .clock(clock),
    .sys_rst(sys_rst),
    .mem_if(mem_if)
  );

  logic [SYNC_W-1:0] sync1_q, sync2_q;
  logic rst_n_s, pclk_s, pcs_n_s, tck_s, tdi_s;
  logic [1:0] mode_s;
  logic [2:0] lw_s;
  logic [3:0] fio_s;
  logic [31:0] pdata_s;
  logic rst_prev_q, pclk_prev_q, tck_prev_q;

  always_ff @(posedge clock)
  begin
    if (sys_rst)
    begin
      sync1_q <= SYNC_RST;
      sync2_q <= SYNC_RST;
      rst_prev_q <= 1'b0;
      pclk_prev_q <= 1'b0;
      tck_prev_q <= 1'b0;
    end
    else
    begin
      sync1_q <= {config_reset_n, pas_clk, pas_cs_n, jtag_tck, jtag_tdi, mode_sel, width_sel, flash_io_i, pas_data};
      sync2_q <= sync1_q;
      rst_prev_q <= rst_n_s;
      pclk_prev_q <= pclk_s;
      tck_prev_q <= tck_s;
    end
  end

  assign {rst_n_s, pclk_s, pcs_n_s, tck_s, tdi_s, mode_s, lw_s, fio_s, pdata_s} = sync2_q;

  fcl_state_t st_q, st_d;
  fcl_mode_t mode_q, mode_d;
  logic [2:0] ph_q, ph_d, lw_q, lw_d;
  logic [8:0] cnt_q, cnt_d;
  logic [31:0] tx_q, tx_d, acc_q, acc_d, wr_data_q, wr_data_d;
  logic [5:0] fill_q, fill_d, wr_addr_q, wr_addr_d;
  logic [6:0] words_q, words_d;
  logic wr_en_q, wr_en_d, sclk_q, sclk_d, cs_n_q, cs_n_d, mosi_q, mosi_d;
  logic oe0_n_q, oe0_n_d, user_q, user_d;
  logic take, bit_end, rst_rise;
  logic [31:0] chunk;
  logic [5:0] fsum;

  // a rising edge of the synchronised reset pin starts a load
  assign rst_rise = rst_n_s && !rst_prev_q; // see R1

  always_comb
  begin
    st_d = st_q;
    mode_d = mode_q;
    lw_d = lw_q;
    ph_d = ph_q;
    cnt_d = cnt_q;
    tx_d = tx_q;
    acc_d = acc_q;
    fill_d = fill_q;
    words_d = words_q;
    wr_en_d = 1'b0;
    wr_addr_d = wr_addr_q;
    wr_data_d = wr_data_q;
    take = 1'b0;
    chunk = WORD_RST;
    fsum = 6'h00;
    bit_end = (ph_q == SPI_PH_LAST);
    if (spi_busy(st_q))
    begin
      ph_d = ph_q + 3'h1; // see R2
    end
    if (spi_busy(st_q) && bit_end)
    begin
      tx_d = {tx_q[30:0], 1'b0};
    end
    unique case (st_q)
      ST_IDLE:
      begin
        if (rst_rise)
        begin
          acc_d = WORD_RST;
          fill_d = 6'h00;
          words_d = 7'h00;
          wr_addr_d = 6'h00;
          ph_d = 3'h0;
          // illegal widths are clamped to the widest legal one
          if (mode_s == 2'h1)
          begin
            mode_d = MODE_PASSIVE;
            lw_d = (lw_s > LW_PASSIVE_MAX) ? LW_PASSIVE_MAX : lw_s; // see R7
            st_d = ST_SLAVE;
          end
          else if (mode_s == 2'h2)
          begin
            mode_d = MODE_JTAG;
            lw_d = LW_JTAG; // see R7
            st_d = ST_SLAVE;
          end
          else
          begin
            mode_d = MODE_ACTIVE;
            lw_d = (lw_s > LW_ACTIVE_MAX) ? LW_ACTIVE_MAX : lw_s; // see R7
            tx_d = {CMD_WAKE, 24'h000000}; // see R3
            cnt_d = WAKE_BITS_LAST;
            st_d = ST_WAKE;
          end
        end
      end
      ST_WAKE:
      begin
        if (bit_end)
        begin
          cnt_d = cnt_q - 9'h001;
          if (cnt_q == 9'h000)
          begin
            cnt_d = 9'h000;
            st_d = ST_WAIT;
          end
        end
      end
      ST_WAIT:
      begin
        cnt_d = cnt_q + 9'h001;
        if (cnt_q == WAIT_LAST) // see R4
        begin
          tx_d = {CMD_FAST_READ, READ_ADDR}; // see R5
          cnt_d = READ_BITS_LAST;
          ph_d = 3'h0;
          st_d = ST_READ_CMD;
        end
      end
      ST_READ_CMD:
      begin
        if (bit_end)
        begin
          cnt_d = (cnt_q == 9'h000) ? DUMMY_BITS_LAST : cnt_q - 9'h001;
          st_d = (cnt_q == 9'h000) ? ST_DUMMY : ST_READ_CMD;
        end
      end
      ST_DUMMY:
      begin
        if (bit_end)
        begin
          cnt_d = cnt_q - 9'h001;
          st_d = (cnt_q == 9'h000) ? ST_DATA : ST_DUMMY;
        end
      end
      ST_DATA:
      begin
        // sampled at the end of the high phase, after the sync delay settles
        take = bit_end; // see R5
        chunk = (lw_q == 3'h0) ? {31'h0, fio_s[1]} : {28'h0, fio_s};
      end
      ST_SLAVE:
      begin
        if (mode_q == MODE_JTAG)
        begin
          take = tck_s && !tck_prev_q; // see R8
          chunk = {31'h0, tdi_s};
        end
        else
        begin
          take = pclk_s && !pclk_prev_q && !pcs_n_s; // see R6
          chunk = pdata_s;
        end
      end
      ST_DONE:
      begin
      end
    endcase
    if (take)
    begin
      acc_d = (acc_q << fcl_bits(lw_q)) | (chunk & fcl_mask(lw_q)); // see R7
      fsum = fill_q + fcl_bits(lw_q);
      fill_d = fsum;
      if (fsum == WORD_BITS)
      begin
        fill_d = 6'h00;
        wr_en_d = 1'b1;
        wr_data_d = acc_d;
        wr_addr_d = words_q[5:0];
        words_d = words_q + 7'h01;
        if (words_d == CFG_WORDS)
        begin
          st_d = ST_DONE; // see R11
        end
      end
    end
    if (!rst_n_s)
    begin
      st_d = ST_IDLE; // see R10
      ph_d = 3'h0;
    end
    sclk_d = spi_busy(st_d) && ph_d[2]; // see R2
    cs_n_d = !spi_busy(st_d);
    mosi_d = tx_d[31];
    oe0_n_d = !((st_d == ST_WAKE) || (st_d == ST_READ_CMD));
    // release on the same clock edge that writes the last word into the memory
    user_d = (st_q == ST_DONE) && rst_n_s; // see R9
  end

  always_ff @(posedge clock)
  begin
    if (sys_rst)
    begin
      st_q <= ST_IDLE;
      mode_q <= MODE_ACTIVE;
      lw_q <= LW_JTAG;
      ph_q <= 3'h0;
      cnt_q <= 9'h000;
      tx_q <= WORD_RST;
      acc_q <= WORD_RST;
      fill_q <= 6'h00;
      words_q <= 7'h00;
      wr_en_q <= 1'b0;
      wr_addr_q <= 6'h00;
      wr_data_q <= WORD_RST;
      sclk_q <= 1'b0;
      cs_n_q <= 1'b1;
      mosi_q <= 1'b0;
      oe0_n_q <= 1'b1;
      user_q <= 1'b0;
    end
    else
    begin
      st_q <= st_d;
      mode_q <= mode_d;
      lw_q <= lw_d;
      ph_q <= ph_d;
      cnt_q <= cnt_d;
      tx_q <= tx_d;
      acc_q <= acc_d;
      fill_q <= fill_d;
      words_q <= words_d;
      wr_en_q <= wr_en_d;
      wr_addr_q <= wr_addr_d;
      wr_data_q <= wr_data_d;
      sclk_q <= sclk_d;
      cs_n_q <= cs_n_d;
      mosi_q <= mosi_d;
      oe0_n_q <= oe0_n_d;
      user_q <= user_d;
    end
  end

  assign mem_if.wr_en = wr_en_q;
  assign mem_if.wr_addr = wr_addr_q;
  assign mem_if.wr_data = wr_data_q;
  assign mem_if.rd_addr = user_rd_addr;
  assign user_rd_data = mem_if.rd_data;
  assign flash_sclk = sclk_q;
  assign flash_cs_n = cs_n_q;
  // upper lanes stay released; they are only ever inputs here
  assign flash_io_o = {3'h7, mosi_q};
  assign flash_io_oe_n = {3'h7, oe0_n_q};
  assign user_mode = user_q;

  AST_CLK_ACTIVE_ONLY: assert property (@(posedge clock) disable iff (sys_rst) // see R2
    sclk_q |-> (mode_q == MODE_ACTIVE) && !cs_n_q)
    else $error("flash clock toggles outside an active load");

  AST_WAKE_FIRST: assert property (@(posedge clock) disable iff (sys_rst) // see R3
    $rose(st_q == ST_WAKE) |-> ($past(st_q) == ST_IDLE) && (tx_q[31:24] == CMD_WAKE) && !oe0_n_q)
    else $error("first flash command is not the wake command");

  AST_WAKE_WAIT: assert property (@(posedge clock) disable iff (sys_rst) // see R4
    $rose(st_q == ST_READ_CMD) |-> ($past(cnt_q) == WAIT_LAST) && $past(cs_n_q))
    else $error("fast read issued before the wake wait elapsed");

  AST_FAST_READ_ZERO: assert property (@(posedge clock) disable iff (sys_rst) // see R5
    $rose(st_q == ST_READ_CMD) |-> (tx_q == {CMD_FAST_READ, READ_ADDR}) ##1 (!cs_n_q || !$past(rst_n_s)))
    else $error("fast read command or start address wrong");

  AST_WIDTH_LEGAL: assert property (@(posedge clock) disable iff (sys_rst) // see R7
    (st_q != ST_IDLE) |-> ((mode_q == MODE_ACTIVE) && (lw_q <= LW_ACTIVE_MAX))
      || ((mode_q == MODE_PASSIVE) && (lw_q <= LW_PASSIVE_MAX)) || ((mode_q == MODE_JTAG) && (lw_q == LW_JTAG)))
    else $error("data width not legal for the mode");

  AST_JTAG_SHIFT: assert property (@(posedge clock) disable iff (sys_rst) // see R8
    (st_q == ST_SLAVE) && (mode_q == MODE_JTAG) && tck_s && !tck_prev_q && rst_n_s |=> acc_q[0] == $past(tdi_s))
    else $error("jtag bit not taken on clock edge");

  AST_NO_EARLY_USER: assert property (@(posedge clock) disable iff (sys_rst) // see R9
    user_mode |-> (words_q == CFG_WORDS) && (st_q == ST_DONE))
    else $error("user mode entered before load complete");

  AST_IDLE_IN_RESET: assert property (@(posedge clock) disable iff (sys_rst) // see R10
    !rst_n_s |=> (st_q == ST_IDLE) && cs_n_q && !sclk_q && !user_mode)
    else $error("loader active while configuration reset held");

  AST_RELEASE_AFTER_LAST: assert property (@(posedge clock) disable iff (sys_rst) // see R11
    wr_en_q && (wr_addr_q == 6'h3F) && rst_n_s |=> user_mode)
    else $error("user mode not released after the last word");
endmodule

/* File: fcl_flash_model.sv */
// Purpose: behavioural serial flash that answers the loader
// Assumes: commands arrive x1 on io0, mode 0 clocking
// Notes: released lines show the inverse of their last value, never a stale copy
module fcl_flash_model (
  // flash pins
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic io0,
  input wire logic [2:0] lw,
  output logic [3:0] io
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [31:0] sh;
  logic [23:0] addr;
  logic [7:0] ops[$];
  int rc;

  function automatic logic [31:0] pat(int w);
    return 32'h9E3779B9 * (w + 1);
  endfunction

  // chunk n of the stream, msb first; x1 on io[1], x2 on io[1:0]
  function automatic logic [3:0] chunk(int n);
    int wb;
    logic [31:0] wd;
    logic [3:0] v;
    wb = 1 << lw;
    wd = pat(n * wb / 32) << ((n * wb) % 32);
    v = wd[31:28] >> (4 - wb);
    return (wb == 1) ? {4{v[0]}} : (wb == 2) ? {2{v[1:0]}} : v;
  endfunction

  initial io = 4'hF;
  always @(negedge cs_n) rc = 0;
  always @(posedge sclk)
  begin
    if (!cs_n)
    begin
      sh = {sh[30:0], io0};
      rc++;
      if (rc == 8) ops.push_back(sh[7:0]);
      if (rc == 32) addr = sh[23:0];
    end
  end
  // data after opcode, 24 address bits and 8 dummy clocks, sequential from there
  always @(negedge sclk or posedge cs_n)
  begin
    if (!cs_n && rc >= 40 && ops.size() > 0 && ops[$] == 8'h0B) io = chunk(rc - 40);
    else io = ~io;
  end
endmodule

/* File: tb.sv */
// Purpose: self-checking bench of the configuration loader
// Assumes: 10 MHz clock, link clocks of 800 ns made by the bench
// Notes: each completed load uses a data pattern other than the completed load before it, so stale memory cannot pass
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic clock, sys_rst, config_reset_n, pas_clk, pas_cs_n, jtag_tck, jtag_tdi;
  logic flash_sclk, flash_cs_n, user_mode;
  logic [1:0] mode_sel;
  logic [2:0] width_sel;
  logic [31:0] pas_data, user_rd_data;
  logic [5:0] user_rd_addr;
  logic [3:0] flash_io_o, flash_io_oe_n, fm_io, flash_io_i;
  int error_cnt, comparisons;

  assign flash_io_i = {fm_io[3:1], flash_io_oe_n[0] ? fm_io[0] : flash_io_o[0]};

  fcl_loader u_fcl_loader (.clock(clock), .sys_rst(sys_rst), .config_reset_n(config_reset_n),
    .mode_sel(mode_sel), .width_sel(width_sel), .flash_sclk(flash_sclk), .flash_cs_n(flash_cs_n),
    .flash_io_o(flash_io_o), .flash_io_oe_n(flash_io_oe_n), .flash_io_i(flash_io_i), .pas_clk(pas_clk),
    .pas_cs_n(pas_cs_n), .pas_data(pas_data), .jtag_tck(jtag_tck), .jtag_tdi(jtag_tdi),
    .user_mode(user_mode), .user_rd_addr(user_rd_addr), .user_rd_data(user_rd_data));
  fcl_flash_model u_fcl_flash_model (.sclk(flash_sclk), .cs_n(flash_cs_n), .io0(flash_io_i[0]),
    .lw(width_sel), .io(fm_io));

  task automatic step(int n);
    repeat (n) @(posedge clock);
    #10;
  endtask

  task automatic check(string what, logic [31:0] exp, logic [31:0] got);
    comparisons++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic start(logic [1:0] m, logic [2:0] w);
    config_reset_n = 1'b0;
    mode_sel = m;
    width_sel = w;
    step(8);
    check("flash_cs_n held", 32'h1, 32'(flash_cs_n));
    check("user_mode held", 32'h0, 32'(user_mode));
    check("flash_io_oe_n idle", 32'hF, 32'(flash_io_oe_n));
    check("flash_io_o upper", 32'h7, 32'(flash_io_o[3:1]));
    u_fcl_flash_model.ops.delete();
    config_reset_n = 1'b1;
    step(1);
  endtask

  task automatic wait_done(int lim);
    int i;
    i = 0;
    while (user_mode !== 1'b1 && i < lim)
    begin
      step(1);
      i++;
    end
    check("user_mode", 32'h1, 32'(user_mode));
  endtask

  task automatic check_mem(int off);
    for (int a = 0; a < 64; a++)
    begin
      user_rd_addr = 6'(a);
      step(2);
      check("config_memory word", u_fcl_flash_model.pat(a + off), user_rd_data);
    end
  endtask

  // link clock of 800 ns, data set while the clock is low
  task automatic send(logic pas, logic cs, int w, int off, int words);
    logic [31:0] d;
    int wb;
    wb = 1 << w;
    pas_cs_n = cs;
    for (int k = 0; k < words; k++)
    begin
      for (int c = 0; c < 32 / wb; c++)
      begin
        d = u_fcl_flash_model.pat(k + off) << (c * wb);
        pas_data = d >> (32 - wb);
        jtag_tdi = d[31];
        if (pas) pas_clk = 1'b0;
        else jtag_tck = 1'b0;
        step(4);
        if (pas) pas_clk = 1'b1;
        else jtag_tck = 1'b1;
        step(4);
      end
    end
    pas_cs_n = 1'b1;
  endtask

  task automatic t_abort();
    int i;
    i = 0;
    start(2'h0, 3'h0);
    while (u_fcl_flash_model.rc < 60 && i < 3000)
    begin
      step(1);
      i++;
    end
    config_reset_n = 1'b0;
    step(5);
    check("flash_cs_n abort", 32'h1, 32'(flash_cs_n));
    check("flash_sclk abort", 32'h0, 32'(flash_sclk));
    check("user_mode abort", 32'h0, 32'(user_mode));
    start(2'h0, 3'h2);
    wait_done(6000);
    check("first command", 32'hAB, 32'(u_fcl_flash_model.ops[0]));
    check_mem(0);
  endtask

  task automatic t_passive();
    start(2'h1, 3'h3);
    send(1'b1, 1'b1, 3, 200, 1);
    send(1'b1, 1'b0, 3, 64, 64);
    wait_done(50);
    check("flash_cs_n passive", 32'h1, 32'(flash_cs_n));
    check_mem(64);
  endtask

  task automatic t_jtag();
    start(2'h2, 3'h0);
    send(1'b0, 1'b1, 0, 128, 64);
    wait_done(50);
    send(1'b0, 1'b1, 0, 300, 1);
    check_mem(128);
  endtask

  task automatic t_active();
    int i, gap;
    i = 0;
    gap = 0;
    start(2'h0, 3'h0);
    while (u_fcl_flash_model.ops.size() == 0 && i < 200)
    begin
      step(1);
      i++;
    end
    while (flash_cs_n !== 1'b1 && i < 400)
    begin
      step(1);
      i++;
    end
    while (flash_cs_n === 1'b1 && gap < 2000)
    begin
      step(1);
      gap++;
    end
    check("wake wait at least 300", 32'h1, 32'(gap >= 300));
    wait_done(20000);
    check("wake command", 32'hAB, 32'(u_fcl_flash_model.ops[0]));
    check("read command", 32'h0B, 32'(u_fcl_flash_model.ops[1]));
    check("read address", 32'h0, 32'(u_fcl_flash_model.addr));
    check_mem(0);
  endtask

  // clamped passive width runs x32; strap 3 loads as active at x2
  task automatic t_widths();
    start(2'h1, 3'h7);
    send(1'b1, 1'b0, 5, 400, 64);
    wait_done(50);
    check_mem(400);
    start(2'h3, 3'h1);
    wait_done(12000);
    check("wake command x2", 32'hAB, 32'(u_fcl_flash_model.ops[0]));
    check("read command x2", 32'h0B, 32'(u_fcl_flash_model.ops[1]));
    check_mem(0);
  endtask

  task automatic results();
    if (error_cnt == 0 && comparisons > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  initial
  begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end

  initial
  begin
    #8000000;
    error_cnt++;
    results();
  end

  initial
  begin
    error_cnt = 0;
    comparisons = 0;
    sys_rst = 1'b1;
    config_reset_n = 1'b0;
    mode_sel = 2'h0;
    width_sel = 3'h0;
    pas_clk = 1'b0;
    pas_cs_n = 1'b1;
    pas_data = 32'h0;
    jtag_tck = 1'b0;
    jtag_tdi = 1'b0;
    user_rd_addr = 6'h0;
    repeat (6) @(posedge clock);
    #10;
    sys_rst = 1'b0;
    step(2);
    t_abort();
    t_passive();
    t_jtag();
    t_active();
    t_widths();
    results();
  end
endmodule
